// ---- usck_top.sv ----
// Purpose: Serial port clock modes, transmit buffer and receive FIFO.
// Assumes: All inputs are synchronous to ref_clk except xck_in.
// Notes:   Frames are one start bit, 8 or 9 data, optional parity, one stop.
//
// How it works
// - Four clock modes; sync mode select picks asynchronous or synchronous.
// - In sync mode pin direction picks master or slave clock.
// - Transfer clock pin used only in synchronous mode.
// - Baud counter runs at system clock, reloads at zero or low write.
// - One baud tick per counter zero, rate clock over divisor plus one.
// - Transmitter divides baud ticks by 16, 8 or 2.
// - Receiver recovery uses baud ticks with 16, 8 or 2 states.
// - Baud divisor is twelve bits from high and low parts.
// - Double speed receiver uses 8 states per bit and samples once at mid count.
// - Slave clock passes synchroniser and edge detector, two clocks late.
// - Input sampled on opposite clock edge to output change.
// - One transmit buffer allows frames back to back.
// - Receive buffer is two-entry FIFO, each data read pops.
// - Error flags and ninth bit travel with each FIFO entry.
// - Shift register holds a third frame; overrun on next start.
// - Receiver checks frame, overrun and parity errors.
// - Polarity zero changes data on rising, samples on falling edge.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module usck_top
  import usck_pkg::*;
#(
  parameter int unsigned BAUD_W = 12
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Serial pins
  input  wire logic              rxd,
  output logic                   txd,
  input  wire logic              xck_in,
  output logic                   xck_out,
  output logic                   xck_oe
);

  generate
    if (BAUD_W < 9 || BAUD_W > 16)
    begin : g_bad_width
      $error("usck_top: baud width out of range");
    end
  endgenerate

  usck_ctrl_type      ctrl_r;
  logic [7:0]         baud_lo_r;
  logic [BAUD_W-9:0]  baud_hi_r;
  logic [BAUD_W-1:0]  baud_nxt;
  logic               lo_wr;
  logic               data_wr;
  logic               data_rd;
  logic               baud_tick;
  logic               sync_m;
  logic               master;
  logic               slave;
  logic               pol;
  logic [3:0]         os_last;
  logic [3:0]         os_mid;
  logic               xck_meta_r;
  logic               xck_sync_r;
  logic               xck_prev_r;
  logic               x_rise;
  logic               x_fall;
  logic               sync_change;
  logic               sync_sample;
  logic [3:0]         tx_div_r;
  logic               tx_step;
  logic [7:0]         txbuf_r;
  logic               txbuf_full_r;
  logic [11:0]        tx_frame;
  logic [3:0]         tx_len;
  logic [8:0]         tx_d9;
  logic [11:0]        tx_sh_r;
  logic [3:0]         tx_left_r;
  logic               txd_r;
  logic               tx_load;
  logic               xck_out_r;
  logic               xck_oe_r;
  usck_rx_state_type  rx_state_r;
  logic [3:0]         rx_cnt_r;
  logic [3:0]         rx_nb_r;
  logic [9:0]         rx_sh_r;
  logic [3:0]         rx_nbits;
  logic               rx_start;
  logic               rx_strobe;
  logic               rx_done;
  logic [9:0]         rx_al;
  usck_rx_entry_type  new_entry;
  usck_rx_entry_type  fifo_mem [2];
  usck_rx_entry_type  hold_r;
  usck_rx_entry_type  head;
  logic               hold_v_r;
  logic               ovr_r;
  logic               wp_r;
  logic               rp_r;
  logic [1:0]         cnt_r;
  logic               pop;
  logic               space;
  logic               push_hold;
  logic               push_new;
  logic [7:0]         rdata_r;
  logic [7:0]         status;

  assign lo_wr   = reg_wr && reg_addr == ADDR_BAUD_LO;
  assign data_wr = reg_wr && reg_addr == ADDR_DATA;
  assign data_rd = reg_rd && reg_addr == ADDR_DATA;

  // The new low byte goes straight into the counter on its write.
  assign baud_nxt = lo_wr ? {baud_hi_r, reg_wdata} : {baud_hi_r, baud_lo_r};

  usck_baud #(.W(BAUD_W)) u_baud (
    .clk     (ref_clk),
    .rst     (rst),
    .divisor (baud_nxt),
    .reload  (lo_wr),
    .tick    (baud_tick)
  );

  assign sync_m  = ctrl_r.sync_mode_select;
  assign master  = sync_m && ctrl_r.xfer_clock_pin_direction;
  assign slave   = sync_m && !ctrl_r.xfer_clock_pin_direction;
  assign pol     = ctrl_r.sync_clock_polarity;
  // Double speed is ignored whenever sync mode is on.
  assign os_last = ctrl_r.double_speed ? OS_DOUBLE_LAST : OS_NORMAL_LAST;
  assign os_mid  = ctrl_r.double_speed ? OS_DOUBLE_MID : OS_NORMAL_MID;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_r    <= CTRL_RESET;
      baud_lo_r <= '0;
      baud_hi_r <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
        ctrl_r <= reg_wdata;
      if (reg_addr == ADDR_BAUD_LO)
        baud_lo_r <= reg_wdata;
      if (reg_addr == ADDR_BAUD_HI)
        baud_hi_r <= reg_wdata[BAUD_W-9:0];
    end
  end

  // Slave clock: the first stage feeds only the second stage.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xck_meta_r <= 1'b0;
      xck_sync_r <= 1'b0;
      xck_prev_r <= 1'b0;
    end
    else
    begin
      xck_meta_r <= xck_in;
      xck_sync_r <= xck_meta_r;
      xck_prev_r <= xck_sync_r;
    end
  end

  assign x_rise = slave && xck_sync_r && !xck_prev_r;
  assign x_fall = slave && !xck_sync_r && xck_prev_r;

  // Master clock toggles per tick, giving a divide by two.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !master)
      xck_out_r <= 1'b0;
    else if (baud_tick)
      xck_out_r <= !xck_out_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      xck_oe_r <= 1'b0;
    else
      xck_oe_r <= master;
  end

  // Change and sample happen on opposite transfer clock edges.
  assign sync_change = (baud_tick && master && xck_out_r == pol)
                     || (pol ? x_fall : x_rise);
  assign sync_sample = (baud_tick && master && xck_out_r != pol)
                     || (pol ? x_rise : x_fall);

  always_ff @(posedge ref_clk)
  begin
    if (rst || sync_m)
      tx_div_r <= '0;
    else if (baud_tick)
      tx_div_r <= (tx_div_r == os_last) ? 4'h0 : tx_div_r + 4'h1;
  end

  assign tx_step = sync_m ? sync_change : (baud_tick && tx_div_r == os_last);

  always_comb
  begin
    tx_d9    = {ctrl_r.tx_ninth_bit && ctrl_r.char9, txbuf_r};
    tx_frame = '1;
    tx_frame[0]   = 1'b0;
    tx_frame[8:1] = txbuf_r;
    if (ctrl_r.char9)
      tx_frame[9] = ctrl_r.tx_ninth_bit;
    if (ctrl_r.parity_en && ctrl_r.char9)
      tx_frame[10] = ^tx_d9 ^ ctrl_r.parity_odd;
    else if (ctrl_r.parity_en)
      tx_frame[9] = ^tx_d9 ^ ctrl_r.parity_odd;
    tx_len = FRAME_MIN_LEN + {3'h0, ctrl_r.char9} + {3'h0, ctrl_r.parity_en};
  end

  // Loading right after the last stop bit leaves no idle gap.
  assign tx_load = tx_step && tx_left_r == 4'h0 && txbuf_full_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txd_r     <= 1'b1;
      tx_sh_r   <= '1;
      tx_left_r <= '0;
    end
    else if (tx_step && tx_left_r != 4'h0)
    begin
      txd_r     <= tx_sh_r[0];
      tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
      tx_left_r <= tx_left_r - 4'h1;
    end
    else if (tx_load)
    begin
      txd_r     <= tx_frame[0];
      tx_sh_r   <= {1'b1, tx_frame[11:1]};
      tx_left_r <= tx_len - 4'h1;
    end
  end

  // A write while full replaces the waiting byte.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txbuf_r      <= '0;
      txbuf_full_r <= 1'b0;
    end
    else if (data_wr)
    begin
      txbuf_r      <= reg_wdata;
      txbuf_full_r <= 1'b1;
    end
    else if (tx_load)
      txbuf_full_r <= 1'b0;
  end

  assign rx_nbits  = DATA_BITS + {3'h0, ctrl_r.char9} + {3'h0, ctrl_r.parity_en};
  assign rx_start  = rx_state_r == RX_IDLE && !rxd
                   && (sync_m ? sync_sample : baud_tick);
  assign rx_strobe = sync_m ? sync_sample : (baud_tick && rx_cnt_r == os_mid);
  assign rx_done   = rx_state_r == RX_STOP && rx_strobe;

  always_ff @(posedge ref_clk)
  begin
    if (rst || rx_start)
      rx_cnt_r <= '0;
    else if (baud_tick)
      rx_cnt_r <= (rx_cnt_r == os_last) ? 4'h0 : rx_cnt_r + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_state_r <= RX_IDLE;
      rx_nb_r    <= '0;
      rx_sh_r    <= '0;
    end
    else
    begin
      unique case (rx_state_r)
        RX_IDLE:
          if (rx_start)
          begin
            rx_state_r <= sync_m ? RX_DATA : RX_START;
            rx_nb_r    <= '0;
          end
        RX_START:
          if (rx_strobe)
            rx_state_r <= rxd ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_strobe)
          begin
            rx_sh_r <= {rxd, rx_sh_r[9:1]};
            rx_nb_r <= rx_nb_r + 4'h1;
            if (rx_nb_r == rx_nbits - 4'h1)
              rx_state_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_strobe)
            rx_state_r <= RX_IDLE;
      endcase
    end
  end

  assign rx_al = rx_sh_r >> (RX_SH_LEN - rx_nbits);

  always_comb
  begin
    new_entry.data             = ctrl_r.char9 ? rx_al[8:0] : {1'b0, rx_al[7:0]};
    new_entry.frame_error_flag = !rxd;
    new_entry.overrun_flag     = ovr_r;
    new_entry.parity_error     = ctrl_r.parity_en
      && ((ctrl_r.char9 ? rx_al[9] : rx_al[8])
          != (^new_entry.data ^ ctrl_r.parity_odd));
  end

  assign pop       = data_rd && cnt_r != 2'h0;
  assign space     = cnt_r != 2'h2 || pop;
  assign push_hold = hold_v_r && space;
  assign push_new  = rx_done && space && !hold_v_r;
  assign head      = fifo_mem[rp_r];

  always_ff @(posedge ref_clk)
  begin
    if (push_hold || push_new)
      fifo_mem[wp_r] <= push_hold ? hold_r : new_entry;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      if (push_hold || push_new)
        wp_r <= !wp_r;
      if (pop)
        rp_r <= !rp_r;
      cnt_r <= cnt_r + {1'b0, push_hold || push_new} - {1'b0, pop};
    end
  end

  // The shift register keeps a finished frame until a FIFO place frees or the next start bit.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hold_r   <= '0;
      hold_v_r <= 1'b0;
      ovr_r    <= 1'b0;
    end
    else
    begin
      if (rx_done && !push_new)
      begin
        hold_r   <= new_entry;
        hold_v_r <= 1'b1;
      end
      else if (push_hold || (rx_start && hold_v_r))
        hold_v_r <= 1'b0;
      if (rx_start && hold_v_r)
        ovr_r <= 1'b1;
      else if (rx_done)
        ovr_r <= 1'b0;
    end
  end

  always_comb
  begin
    status               = '0;
    status[ST_RX_VALID]  = cnt_r != 2'h0;
    status[ST_TX_EMPTY]  = !txbuf_full_r;
    status[ST_FRAME_ERR] = status[ST_RX_VALID] && head.frame_error_flag;
    status[ST_OVERRUN]   = status[ST_RX_VALID] && head.overrun_flag;
    status[ST_PARITY]    = status[ST_RX_VALID] && head.parity_error;
    status[ST_NINTH]     = status[ST_RX_VALID] && head.data[8];
    status[ST_TX_IDLE]   = tx_left_r == 4'h0 && !txbuf_full_r;
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !reg_rd)
      rdata_r <= '0;
    else
    begin
      unique case (reg_addr)
        ADDR_CTRL:    rdata_r <= ctrl_r;
        ADDR_STATUS:  rdata_r <= status;
        ADDR_BAUD_LO: rdata_r <= baud_lo_r;
        ADDR_BAUD_HI: rdata_r <= 8'(baud_hi_r);
        ADDR_DATA:    rdata_r <= status[ST_RX_VALID] ? head.data[7:0] : 8'h00;
        default:      rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign txd       = txd_r;
  assign xck_out   = xck_out_r;
  assign xck_oe    = xck_oe_r;

  // Checking helpers: baud ticks counted between transmit steps.
  logic [3:0] tk_since_r;
  logic       tk_seen_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst || (reg_wr && reg_addr == ADDR_CTRL) || lo_wr)
    begin
      tk_since_r <= '0;
      tk_seen_r  <= 1'b0;
    end
    else if (tx_step)
    begin
      tk_since_r <= '0;
      tk_seen_r  <= 1'b1;
    end
    else if (baud_tick)
      tk_since_r <= tk_since_r + 4'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_oe_sync;
    ##1 xck_oe == $past(sync_m && ctrl_r.xfer_clock_pin_direction);
  endproperty
  a_oe_sync: assert property (p_oe_sync) else $error("pin drive mode wrong");

  property p_tx_div;
    (tk_seen_r && !sync_m && tx_step) |-> tk_since_r == os_last;
  endproperty
  a_tx_div: assert property (p_tx_div) else $error("tx divide wrong");

  property p_slave_edge;
    ##3 (slave && $past(slave)) |-> x_rise == ($past(xck_in, 2) && !$past(xck_in, 3));
  endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("slave edge late");

  property p_txd_edge;
    ##1 (txd != $past(txd)) |-> $past(tx_step);
  endproperty
  a_txd_edge: assert property (p_txd_edge) else $error("txd moved off step");

  property p_back_to_back;
    tx_load |=> (tx_left_r != 4'h0 && !txd && !txbuf_full_r) or ##0 txbuf_full_r;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("buffer not loaded");

  property p_pop;
    (pop && !(push_hold || push_new)) |=> cnt_r == $past(cnt_r) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("fifo pop wrong");

  property p_overrun;
    (rx_start && hold_v_r) |=> (ovr_r && !hold_v_r);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_reset;
    @(posedge ref_clk) disable iff (1'b0)
    rst |=> (cnt_r == 2'h0 && !txbuf_full_r && !ovr_r && !hold_v_r && txd);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  c_back_to_back: cover property (data_wr && tx_left_r != 4'h0);
  c_third_level:  cover property (rx_done && !space);
  c_overrun:      cover property (rx_start && hold_v_r);
  c_master_tx:    cover property (master && tx_load);

endmodule // usck_top

`default_nettype wire

// ---- usck_pkg.sv ----
// Purpose: Shared constants and types for the serial clock and buffer block.
// Assumes: Register port is a plain strobe port with eight data bits.
// Notes:   Register offsets and bit positions are local to this block.
`default_nettype none

package usck_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [2:0] ADDR_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h2;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h3;
  localparam logic [2:0] ADDR_DATA    = 3'h4;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Oversampling states per bit, as last count and mid count.
  localparam logic [3:0] OS_NORMAL_LAST = 4'hF;
  localparam logic [3:0] OS_DOUBLE_LAST = 4'h7;
  localparam logic [3:0] OS_NORMAL_MID  = 4'h8;
  localparam logic [3:0] OS_DOUBLE_MID  = 4'h4;

  // Frame shape.
  localparam logic [3:0] DATA_BITS     = 4'h8;
  localparam logic [3:0] FRAME_MIN_LEN = 4'hA;
  localparam logic [3:0] RX_SH_LEN     = 4'hA;

  // Status bit positions.
  localparam int unsigned ST_RX_VALID  = 0;
  localparam int unsigned ST_TX_EMPTY  = 1;
  localparam int unsigned ST_FRAME_ERR = 2;
  localparam int unsigned ST_OVERRUN   = 3;
  localparam int unsigned ST_PARITY    = 4;
  localparam int unsigned ST_NINTH     = 5;
  localparam int unsigned ST_TX_IDLE   = 6;

  typedef struct packed {
    logic tx_ninth_bit;
    logic parity_odd;
    logic parity_en;
    logic char9;
    logic sync_clock_polarity;
    logic xfer_clock_pin_direction;
    logic double_speed;
    logic sync_mode_select;
  } usck_ctrl_type;

  typedef struct packed {
    logic       frame_error_flag;
    logic       overrun_flag;
    logic       parity_error;
    logic [8:0] data;
  } usck_rx_entry_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } usck_rx_state_type;

endpackage

`default_nettype wire

// ---- usck_baud.sv ----
// Purpose: Baud down-counter giving one tick per divisor plus one clocks.
// Assumes: Reload value already holds the new low byte on a reload.
// Notes:   Tick comes from a flip-flop, one cycle after the zero count.
`timescale 1ns/100ps
`default_nettype none

module usck_baud
  import usck_pkg::*;
#(
  parameter int unsigned W = 12
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Divisor control
  input  wire logic [W-1:0] divisor,
  input  wire logic         reload,
  // Baud output
  output logic              tick
);

  logic [W-1:0] cnt_r;

  generate
    if (W < 9 || W > 16)
    begin : g_bad_width
      $error("usck_baud: width out of range");
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (reload)
    begin
      cnt_r <= divisor;
      tick  <= 1'b0;
    end
    else if (cnt_r == '0)
    begin
      cnt_r <= divisor;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r - W'(1);
      tick  <= 1'b0;
    end
  end

  property p_reload;
    @(posedge clk) disable iff (rst)
    (cnt_r == '0 && !reload) |=> (tick && cnt_r == $past(divisor));
  endproperty
  a_reload: assert property (p_reload) else $error("baud reload missed");

  property p_count;
    @(posedge clk) disable iff (rst)
    (cnt_r != '0 && !reload) |=> (!tick && cnt_r == $past(cnt_r) - W'(1));
  endproperty
  a_count: assert property (p_count) else $error("baud count wrong");

endmodule // usck_baud

`default_nettype wire

// ---- usck_peer.sv ----
// Purpose: Remote serial transmitter that drives whole frames onto the receive line.
// Assumes: Bit time is given in system clocks and matches the device setting.
// Notes:   The line idles high between frames, so a lost bit shows as a mark, not a guess.
`timescale 1ns/100ps
`default_nettype none

module usck_peer
(
  // Clock
  input  wire logic        ref_clk,
  // Frame request
  input  wire logic        go,
  input  wire logic [7:0]  byte_in,
  input  wire logic        stop_bit,
  input  wire logic [15:0] bit_len,
  // Serial line
  output logic             line
);
  logic [9:0] frame;

  initial
  begin
    line = 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (go)
      begin
        // Start bit, data least significant first, then the stop bit.
        frame = {stop_bit, byte_in, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
          line <= frame[i];
          repeat (bit_len) @(posedge ref_clk);
        end
        line <= 1'b1;
      end
    end
  end
endmodule // usck_peer

`default_nettype wire

// ---- usart_clock_gen_and_buffering_bench.sv ----
// Purpose: Self-checking bench for clock modes, transmit buffer and receive FIFO.
// Assumes: Baud divisor 1, so an asynchronous bit lasts 32 clocks, or 16 with double speed; a master bit lasts 4.
// Notes:   Expected reads and frames wait in queues until the monitors see results.
`timescale 1ns/100ps
`default_nettype none

module usart_clock_gen_and_buffering_bench
  import usck_pkg::*;
;

  logic              ref_clk, rst, reg_wr, reg_rd, rxd, txd, xck_in, xck_out, xck_oe;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              go, pstop, rd_q, b2b;
  logic [7:0]        pbyte;
  logic [7:0]        rb [4];
  logic [15:0]       bit_len;
  logic [7:0]        exp_rd [$];
  logic [8:0]        exp_tx [$];
  int                n_errors, tests_run, n, idle;

  usck_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
    .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe));
  usck_peer u_peer (.ref_clk(ref_clk), .go(go), .byte_in(pbyte), .stop_bit(pstop),
    .bit_len(bit_len), .line(rxd));

  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task wr(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(logic [2:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task send(logic [7:0] b, logic s);
    @(posedge ref_clk);
    pbyte <= b;
    pstop <= s;
    go    <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (10 * bit_len + 2) @(posedge ref_clk);
  endtask

  task span(output int c);
    logic t;
    t = xck_out;
    c = 0;
    while (xck_out === t && c < 50)
    begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= 50)
      n_errors++;
  endtask

  task give_verdict;
    if (exp_rd.size() != 0 || exp_tx.size() != 0)
      n_errors++;
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read data is only valid in the cycle after the strobe.
  always @(posedge ref_clk)
  begin
    if (rd_q)
      chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
    rd_q <= reg_rd;
  end

  // Frame watcher: samples each bit at its middle and times the gap between frames.
  initial
  begin
    logic [9:0] got;
    logic [8:0] e;
    b2b = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      idle++;
      if (txd === 1'b0 && !rst)
      begin
        if (b2b)
          chk("tx_gap", 8'(bit_len / 2), 8'(idle));
        repeat (bit_len / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
          got[i] = txd;
          if (i < 9)
            repeat (bit_len) @(posedge ref_clk);
        end
        e = exp_tx.pop_front();
        chk("tx_data", e[7:0], got[8:1]);
        chk("tx_stop", 8'h01, {7'h00, got[9]});
        b2b  = e[8];
        idle = 0;
      end
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever
      #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; xck_in = 1'b0;
    go = 1'b0; pbyte = '0; pstop = 1'b1; bit_len = 16'd32;
    void'($urandom(19));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, 8'h42);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_DATA, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    wr(ADDR_BAUD_HI, 8'hFF);
    rd(ADDR_BAUD_HI, 8'h0F);
    wr(ADDR_BAUD_HI, 8'h00);
    wr(ADDR_BAUD_LO, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CTRL, {6'h00, m[0], 1'b0});
      bit_len = 16'(m ? 16 : 32);
      for (int k = 0; k < 4; k++)
        rb[k] = 8'($urandom);
      exp_tx.push_back({1'b1, rb[0]});
      exp_tx.push_back({1'b0, rb[1]});
      wr(ADDR_DATA, rb[0]);
      // One buffer place: let the shifter take the first byte, then refill it mid-frame.
      repeat (3 * bit_len) @(posedge ref_clk);
      wr(ADDR_DATA, rb[1]);
      repeat (21 * bit_len) @(posedge ref_clk);
      // Two FIFO places plus the held shift register take three frames.
      for (int k = 0; k < 3; k++)
        send(rb[k], 1'b1);
      for (int k = 0; k < 3; k++)
      begin
        rd(ADDR_STATUS, 8'h43);
        rd(ADDR_DATA, rb[k]);
      end
      rd(ADDR_STATUS, 8'h42);
    end
    // A fourth start with all levels full drops the held frame.
    for (int k = 0; k < 4; k++)
      send(rb[k], 1'b1);
    rd(ADDR_STATUS, 8'h43);
    rd(ADDR_DATA, rb[0]);
    rd(ADDR_STATUS, 8'h43);
    rd(ADDR_DATA, rb[1]);
    rd(ADDR_STATUS, 8'h4B);
    rd(ADDR_DATA, rb[3]);
    send(rb[2], 1'b0);
    rd(ADDR_STATUS, 8'h47);
    rd(ADDR_DATA, rb[2]);
    // Synchronous master: the pin is driven and toggles every divisor plus one clocks.
    wr(ADDR_CTRL, 8'h05);
    span(n);
    span(n);
    chk("xck_half", 8'h02, 8'(n));
    chk("xck_oe", 8'h01, {7'h00, xck_oe});
    // A master bit spans two baud ticks, four clocks at this divisor.
    bit_len = 16'd4;
    exp_tx.push_back({1'b0, rb[3]});
    wr(ADDR_DATA, rb[3]);
    repeat (12 * bit_len) @(posedge ref_clk);
    // Synchronous slave: the pin is an input, clocked well under a quarter rate.
    // Ten rising edges of the far clock carry exactly one frame of eight clocks a bit.
    wr(ADDR_CTRL, 8'h01);
    bit_len = 16'd8;
    exp_tx.push_back({1'b0, rb[2]});
    wr(ADDR_DATA, rb[2]);
    repeat (20)
    begin
      repeat (4) @(posedge ref_clk);
      xck_in <= ~xck_in;
    end
    chk("xck_oe", 8'h00, {7'h00, xck_oe});
    wr(ADDR_CTRL, 8'h00);
    repeat (8) @(posedge ref_clk);
    chk("xck_pin", 8'h00, {6'h00, xck_oe, xck_out});
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule // usart_clock_gen_and_buffering_bench

`default_nettype wire
